//--- core/pce_bit_step.sv
// Purpose: One bit of the CRC feedback shift register.
// Assumes: Bits above poly_length are zero on entry.
// Notes: Purely combinational; chained to get two bits per clock.
`timescale 1ns/10ps
`default_nettype none
module pce_bit_step (
  input wire logic [31:0] crc_in,
  input wire logic bit_in,
  input wire logic [4:0] poly_length,
  input wire logic [31:0] tap_mask,
  output logic [31:0] crc_out
);
  logic fb;

  // The top term feeds back always, whatever the mask holds.
  assign fb = crc_in[poly_length] ^ bit_in;

  // The zero-order term is always fed, so tap bit 0 is never read.
  assign crc_out[0] = fb;

  // Enabled taps XOR the feedback; bits above the length stay clear.
  for (genvar i = 1; i < 32; i++) begin : g_tap
    localparam logic [4:0] IDX = 5'(i);
    assign crc_out[i] = (IDX <= poly_length) ?
      (crc_in[i-1] ^ (tap_mask[i] & fb)) : 1'b0;
  end
endmodule
`default_nettype wire

//--- core/pce_crc_engine.sv
// Purpose: Programmable CRC engine with a width-dependent input FIFO.
// Assumes: APB3/4 master; pstrb selects byte lanes of a write.
// Notes: Engine runs two bits a clock; it takes new words only while the start bit stays set.
// Behaviour
// - Polynomials up to order 32, five-bit length.
// - Set tap bit enables XOR at position.
// - Zero-order term always applied, tap bit ignored.
// - Top term always present regardless of mask.
// - Five-bit field sets word width 1..32.
// - Valid bits per word equal field plus one.
// - FIFO depth 4, 8 or 16 by width.
// - Bytes written; unused upper bits are ignored.
// - Count increments when MSb byte is written.
// - Shift only when started and count nonzero.
// - Word moves to shift buffer, count decrements.
// - Two bits per clock until FIFO drained.
// - Full flag when count reaches depth.
// - Empty flag when count reaches zero.
// - Disabled module empties FIFO, count zero.
`timescale 1ns/10ps
`default_nettype none
module pce_crc_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  logic enable_q;
  logic start_q;
  logic [4:0] poly_length_q;
  logic [4:0] wid_q;
  logic [15:0] tapl_q;
  logic [15:0] taph_q;
  logic [31:0] stage_q;
  logic [31:0] stage_d;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [31:0] buf_q;
  logic [5:0] left_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic [2:0] stat_set;
  logic full_prev_q;
  logic empty_prev_q;
  pce_pkg::pce_state_t state_q;
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic [31:0] rdata;
  logic [31:0] taps;
  logic [31:0] s1;
  logic [31:0] s2;
  logic [31:0] word_mask;
  logic [1:0] msb_lane;
  logic push;
  logic pop;
  logic last;
  logic done_evt;
  logic [31:0] head;
  logic [4:0] count;
  logic [4:0] depth;
  logic full;
  logic empty;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign taps = {taph_q, tapl_q};
  assign depth = pce_pkg::depth_for(wid_q);

  // Read mux and decode; an unmapped address reads zero.
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    if (paddr == pce_pkg::CTRL_OFF) begin
      rdata[pce_pkg::CTRL_EN_BIT] = enable_q;
      rdata[pce_pkg::CTRL_GO_BIT] = start_q;
      rdata[pce_pkg::CTRL_CNT_LSB +: 5] = count;
      rdata[pce_pkg::CTRL_FULL_BIT] = full;
      rdata[pce_pkg::CTRL_EMPTY_BIT] = empty;
      rdata[pce_pkg::CTRL_BUSY_BIT] = (state_q == pce_pkg::PCE_SHIFT);
    end else if (paddr == pce_pkg::CFG_OFF) begin
      rdata[pce_pkg::CFG_POLY_LENGTH_LSB +: 5] = poly_length_q;
      rdata[pce_pkg::CFG_WID_LSB +: 5] = wid_q;
    end else if (paddr == pce_pkg::TAPL_OFF) begin
      rdata[15:0] = tapl_q;
    end else if (paddr == pce_pkg::TAPH_OFF) begin
      rdata[15:0] = taph_q;
    end else if (paddr == pce_pkg::DATL_OFF) begin
      rdata[15:0] = stage_q[15:0];
    end else if (paddr == pce_pkg::DATH_OFF) begin
      rdata[15:0] = stage_q[31:16];
    end else if (paddr == pce_pkg::RES_OFF) begin
      rdata = crc_q;
    end else if (paddr == pce_pkg::STAT_OFF) begin
      rdata[pce_pkg::IRQ_W-1:0] = stat_q;
    end else if (paddr == pce_pkg::MASK_OFF) begin
      rdata[pce_pkg::IRQ_W-1:0] = mask_q;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data is captured in the setup phase so it comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rdata;
    end
  end

  // Control and configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      start_q <= 1'b0;
      poly_length_q <= pce_pkg::POLY_LENGTH_RST;
      wid_q <= pce_pkg::WID_RST;
      tapl_q <= pce_pkg::TAP_RST;
      taph_q <= pce_pkg::TAP_RST;
      mask_q <= 3'h0;
    end else if (wr_acc) begin
      if (paddr == pce_pkg::CTRL_OFF && pstrb[0]) begin
        enable_q <= pwdata[pce_pkg::CTRL_EN_BIT];
        start_q <= pwdata[pce_pkg::CTRL_GO_BIT];
      end
      if (paddr == pce_pkg::CFG_OFF) begin
        if (pstrb[0]) begin
          poly_length_q <= pwdata[pce_pkg::CFG_POLY_LENGTH_LSB +: 5];
        end
        if (pstrb[1]) begin
          wid_q <= pwdata[pce_pkg::CFG_WID_LSB +: 5];
        end
      end
      if (paddr == pce_pkg::TAPL_OFF) begin
        tapl_q[7:0] <= pstrb[0] ? pwdata[7:0] : tapl_q[7:0];
        tapl_q[15:8] <= pstrb[1] ? pwdata[15:8] : tapl_q[15:8];
      end
      if (paddr == pce_pkg::TAPH_OFF) begin
        taph_q[7:0] <= pstrb[0] ? pwdata[7:0] : taph_q[7:0];
        taph_q[15:8] <= pstrb[1] ? pwdata[15:8] : taph_q[15:8];
      end
      if (paddr == pce_pkg::MASK_OFF && pstrb[0]) begin
        mask_q <= pwdata[pce_pkg::IRQ_W-1:0];
      end
    end
  end

  // Data staging: the word is built byte by byte, low half first, and
  // pushed when the byte holding its MSb is written.
  always_comb begin
    stage_d = stage_q;
    push = 1'b0;
    if (wr_acc && paddr == pce_pkg::DATL_OFF) begin
      stage_d[7:0] = pstrb[0] ? pwdata[7:0] : stage_q[7:0];
      stage_d[15:8] = pstrb[1] ? pwdata[15:8] : stage_q[15:8];
      push = (msb_lane == 2'd0 && pstrb[0]) ||
             (msb_lane == 2'd1 && pstrb[1]);
    end else if (wr_acc && paddr == pce_pkg::DATH_OFF) begin
      stage_d[23:16] = pstrb[0] ? pwdata[7:0] : stage_q[23:16];
      stage_d[31:24] = pstrb[1] ? pwdata[15:8] : stage_q[31:24];
      push = (msb_lane == 2'd2 && pstrb[0]) ||
             (msb_lane == 2'd3 && pstrb[1]);
    end
  end

  assign msb_lane = wid_q[4:3];
  // Only field plus one bits are kept; the rest of each byte is dropped.
  assign word_mask = 32'hffff_ffff >> (~wid_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= 32'h0000_0000;
    end else begin
      stage_q <= stage_d;
    end
  end

  // The engine takes a word when idle or when finishing the last one.
  assign last = (state_q == pce_pkg::PCE_SHIFT) &&
                (left_q <= pce_pkg::BITS_PER_CLK);
  assign pop = enable_q && start_q && !empty &&
               ((state_q == pce_pkg::PCE_IDLE) || last);
  assign done_evt = last && !pop;

  pce_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!enable_q),
    .push(push),
    .push_data(stage_d & word_mask),
    .pop(pop),
    .depth(depth),
    .head(head),
    .count(count),
    .full(full),
    .empty(empty)
  );

  // Two chained steps give two bits a clock, MSb first.
  pce_bit_step u_step_hi (
    .crc_in(crc_q),
    .bit_in(buf_q[31]),
    .poly_length(poly_length_q),
    .tap_mask(taps),
    .crc_out(s1)
  );

  pce_bit_step u_step_lo (
    .crc_in(s1),
    .bit_in(buf_q[30]),
    .poly_length(poly_length_q),
    .tap_mask(taps),
    .crc_out(s2)
  );

  // An odd width finishes with a single bit in the last clock.
  always_comb begin
    crc_d = crc_q;
    if (state_q == pce_pkg::PCE_SHIFT) begin
      crc_d = (left_q >= pce_pkg::BITS_PER_CLK) ? s2 : s1;
    end
    if (wr_acc && paddr == pce_pkg::RES_OFF) begin
      crc_d = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= pce_pkg::CRC_RST;
    end else begin
      crc_q <= crc_d;
    end
  end

  // Engine state: the word is left-aligned so bit 31 is always its MSb.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pce_pkg::PCE_IDLE;
      buf_q <= 32'h0000_0000;
      left_q <= 6'h00;
    end else if (!enable_q) begin
      state_q <= pce_pkg::PCE_IDLE;
      left_q <= 6'h00;
    end else if (pop) begin
      state_q <= pce_pkg::PCE_SHIFT;
      buf_q <= head << (~wid_q);
      left_q <= {1'b0, wid_q} + 6'h01;
    end else begin
      case (state_q)
        pce_pkg::PCE_SHIFT: begin
          buf_q <= buf_q << 2;
          if (last) begin
            state_q <= pce_pkg::PCE_IDLE;
            left_q <= 6'h00;
          end else begin
            left_q <= left_q - pce_pkg::BITS_PER_CLK;
          end
        end
        default: begin
          state_q <= pce_pkg::PCE_IDLE;
        end
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle wins over the clear.
  assign stat_set[pce_pkg::IRQ_DONE] = done_evt;
  assign stat_set[pce_pkg::IRQ_FULL] = full && !full_prev_q;
  assign stat_set[pce_pkg::IRQ_EMPTY] = empty && !empty_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'h0;
      full_prev_q <= 1'b0;
      empty_prev_q <= 1'b1;
    end else begin
      full_prev_q <= full;
      empty_prev_q <= empty;
      if (wr_acc && paddr == pce_pkg::STAT_OFF && pstrb[0]) begin
        stat_q <= (stat_q & ~pwdata[pce_pkg::IRQ_W-1:0]) | stat_set;
      end else begin
        stat_q <= stat_q | stat_set;
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // Checks.
  // Clocks since a full-width word was loaded, counted while the module
  // stays enabled; a counter keeps long repetitions out of the property.
  logic [4:0] age_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 5'h00;
    end else if (pop && wid_q == 5'h1f) begin
      age_q <= 5'h01;
    end else if (!enable_q || age_q == 5'h10) begin
      age_q <= 5'h00;
    end else if (age_q != 5'h00) begin
      age_q <= age_q + 5'h01;
    end
  end

  sequence word_load32_s;
    pop && wid_q == 5'h1f;
  endsequence

  sequence msb_push_s;
    push && count < depth && !pop && enable_q;
  endsequence

  full_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    full == (count == (wid_q > 5'h0f ? 5'h04 :
      (wid_q > 5'h07 ? 5'h08 : 5'h10))))
    else $error("full flag without count at depth");

  empty_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (count == 5'h00) == empty)
    else $error("empty flag disagrees with count");

  start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    pop |-> start_q && count != 5'h00)
    else $error("word taken without start or data");

  pop_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    pop && !push |=> count == $past(count) - 5'h01)
    else $error("count did not drop on word take");

  push_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    msb_push_s |=> count == $past(count) + 5'h01)
    else $error("count did not rise on msb byte write");

  two_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == pce_pkg::PCE_SHIFT && !last && enable_q
    |=> left_q == $past(left_q) - 6'h02)
    else $error("shift did not advance two bits");

  word_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    age_q == 5'h10 |-> last)
    else $error("32-bit word did not finish in 16 clocks");

  load_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    word_load32_s |=> left_q == 6'h20)
    else $error("32-bit word loaded with wrong bit count");

  disable_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_q |=> count == 5'h00 && state_q == pce_pkg::PCE_IDLE)
    else $error("disabled module kept words");

  done_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt |=> stat_q[pce_pkg::IRQ_DONE])
    else $error("done event lost");

  crc_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == pce_pkg::PCE_SHIFT && !(wr_acc && paddr == pce_pkg::RES_OFF)
    && (crc_q & ~(32'hffff_ffff >> (~poly_length_q))) == 32'h0 && $stable(poly_length_q)
    |=> (crc_q & ~(32'hffff_ffff >> (~poly_length_q))) == 32'h0)
    else $error("crc bits above length set");
endmodule
`default_nettype wire

//--- core/pce_fifo.sv
// Purpose: Input word FIFO with a depth chosen at run time.
// Assumes: Depth never exceeds the sixteen storage slots.
// Notes: A push while full is dropped; flush empties it at once.
`timescale 1ns/10ps
`default_nettype none
module pce_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  input wire logic [4:0] depth,
  output logic [31:0] head,
  output logic [4:0] count,
  output logic full,
  output logic empty
);
  logic [31:0] mem_q [pce_pkg::FIFO_SLOTS];
  logic [3:0] wr_q;
  logic [3:0] rd_q;
  logic push_ok;
  logic pop_ok;

  assign push_ok = push && (count < depth);
  assign pop_ok = pop && !empty;
  assign full = (count == depth);
  assign empty = (count == 5'h00);
  assign head = mem_q[rd_q];

  // Pointers wrap at sixteen; the count alone enforces the depth.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      count <= 5'h00;
    end else if (flush) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      count <= 5'h00;
    end else begin
      if (push_ok) begin
        wr_q <= wr_q + 4'h1;
      end
      if (pop_ok) begin
        rd_q <= rd_q + 4'h1;
      end
      if (push_ok && !pop_ok) begin
        count <= count + 5'h01;
      end else if (pop_ok && !push_ok) begin
        count <= count - 5'h01;
      end
    end
  end

  // Storage holds no reset; only written slots are ever read.
  always_ff @(posedge pclk) begin
    if (push_ok) begin
      mem_q[wr_q] <= push_data;
    end
  end
endmodule
`default_nettype wire

//--- core/pce_pkg.sv
// Purpose: Shared constants and types of the programmable CRC engine.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes: Offsets are byte addresses on the APB bus.
package pce_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CFG_OFF = 8'h04;
  localparam logic [7:0] TAPL_OFF = 8'h08;
  localparam logic [7:0] TAPH_OFF = 8'h0c;
  localparam logic [7:0] DATL_OFF = 8'h10;
  localparam logic [7:0] DATH_OFF = 8'h14;
  localparam logic [7:0] RES_OFF = 8'h18;
  localparam logic [7:0] STAT_OFF = 8'h1c;
  localparam logic [7:0] MASK_OFF = 8'h20;
  // Field positions of engine_control_1.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CNT_LSB = 8;
  localparam int CTRL_FULL_BIT = 16;
  localparam int CTRL_EMPTY_BIT = 17;
  localparam int CTRL_BUSY_BIT = 18;
  // Field positions of engine_control_2.
  localparam int CFG_POLY_LENGTH_LSB = 0;
  localparam int CFG_WID_LSB = 8;
  // Interrupt status and mask bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FULL = 1;
  localparam int IRQ_EMPTY = 2;
  localparam int IRQ_W = 3;
  // Reset values.
  localparam logic [4:0] POLY_LENGTH_RST = 5'h00;
  localparam logic [4:0] WID_RST = 5'h00;
  localparam logic [15:0] TAP_RST = 16'h0000;
  localparam logic [31:0] CRC_RST = 32'h0000_0000;
  // FIFO storage and the width thresholds that choose its depth.
  localparam int FIFO_SLOTS = 16;
  localparam logic [4:0] WID_BIG = 5'h0f;
  localparam logic [4:0] WID_MID = 5'h08;
  localparam logic [4:0] DEPTH_BIG = 5'h04;
  localparam logic [4:0] DEPTH_MID = 5'h08;
  localparam logic [4:0] DEPTH_SMALL = 5'h10;
  // Bits shifted into the CRC state per clock.
  localparam logic [5:0] BITS_PER_CLK = 6'h02;

  // Engine states, one-hot.
  typedef enum logic [1:0] {
    PCE_IDLE = 2'b01,
    PCE_SHIFT = 2'b10
  } pce_state_t;

  // FIFO depth for a given word width field.
  function automatic logic [4:0] depth_for(input logic [4:0] wid);
    if (wid > WID_BIG) begin
      return DEPTH_BIG;
    end else if (wid >= WID_MID) begin
      return DEPTH_MID;
    end
    return DEPTH_SMALL;
  endfunction
endpackage

//--- verification/pce_crc_engine_tb.sv
// Purpose: Self-checking bench for the programmable CRC engine over APB.
// Assumes: pready may stall; the done poll is bounded by a count of 20 status reads, a stalled access only by the watchdog.
// Notes: Expected CRC values come from a bit-serial reference in here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module pce_crc_engine_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int n_mismatch = 0;
  int checks = 0;
  logic [31:0] rd;
  logic err;
  logic [4:0] wtab [6] = '{5'h1f, 5'h10, 5'h0f, 5'h08, 5'h07, 5'h00};
  int dtab [6] = '{4, 4, 8, 8, 16, 16};

  pce_crc_engine i_pce_crc_engine (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 pclk = ~pclk;
  end

  // Single exit point for the run.
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a stalled access.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  // Bit-serial reference, MSb first, only the low w+1 data bits used.
  function automatic logic [31:0] crc_ref(input logic [31:0] c,
      input logic [4:0] pl, input logic [31:0] tp, input logic [4:0] w,
      input logic [31:0] d);
    logic fb;
    for (int b = 31; b >= 0; b--) begin
      if (b <= int'(w)) begin
        fb = c[pl] ^ d[b];
        c = c << 1;
        c[0] = fb;
        for (int i = 1; i < 32; i++) begin
          c[i] = (i <= int'(pl)) ? (c[i] ^ (tp[i] & fb)) : 1'b0;
        end
      end
    end
    return c;
  endfunction

  // One word through the engine, checked against the reference.
  task automatic run_crc(input logic [4:0] pl, input logic [31:0] tp,
      input logic [4:0] w, input logic [31:0] d, input logic [31:0] sd);
    int n;
    wr(pce_pkg::CTRL_OFF, 32'h0);
    wr(pce_pkg::CFG_OFF, {19'h0, w, 3'h0, pl});
    wr(pce_pkg::TAPL_OFF, {16'h0, tp[15:0]});
    wr(pce_pkg::TAPH_OFF, {16'h0, tp[31:16]});
    wr(pce_pkg::RES_OFF, sd);
    wr(pce_pkg::STAT_OFF, 32'h7);
    wr(pce_pkg::CTRL_OFF, 32'h1);
    wr(pce_pkg::DATL_OFF, {16'h0, d[15:0]});
    wr(pce_pkg::DATH_OFF, {16'h0, d[31:16]});
    rdr(pce_pkg::RES_OFF);
    `CHK("result before start", sd, rd)
    wr(pce_pkg::CTRL_OFF, 32'h3);
    rdr(pce_pkg::CTRL_OFF);
    `CHK("busy", 1'b1, rd[pce_pkg::CTRL_BUSY_BIT])
    n = 0;
    rdr(pce_pkg::STAT_OFF);
    while (rd[pce_pkg::IRQ_DONE] !== 1'b1 && n < 20) begin
      n++;
      rdr(pce_pkg::STAT_OFF);
    end
    `CHK("done", 1'b1, rd[pce_pkg::IRQ_DONE])
    rdr(pce_pkg::RES_OFF);
    `CHK("crc", crc_ref(sd, pl, tp, w, d), rd)
    rdr(pce_pkg::CTRL_OFF);
    `CHK("count drained", 5'h00, rd[12:8])
  endtask

  // Hang guard, sized well above the expected run length.
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdr(pce_pkg::CTRL_OFF);
    `CHK("ctrl reset", 32'h0002_0000, rd)
    rdr(pce_pkg::CFG_OFF);
    `CHK("cfg reset", 32'h0, rd)
    rdr(8'h24);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    `CHK("ready", 1'b1, pready)
    `CHK("irq reset", 1'b0, irq)
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      wr(pce_pkg::CTRL_OFF, 32'h0);
      wr(pce_pkg::CFG_OFF, {19'h0, wtab[k], 8'h1f});
      wr(pce_pkg::STAT_OFF, 32'h7);
      wr(pce_pkg::CTRL_OFF, 32'h1);
      wr(pce_pkg::DATL_OFF, 32'h0000_ffff);
      rdr(pce_pkg::CTRL_OFF);
      `CHK("count after low", {4'h0, ~wtab[k][4]}, rd[12:8])
      wr(pce_pkg::DATH_OFF, 32'h0000_ffff);
      for (int j = 0; j < dtab[k]; j++) begin
        wr(pce_pkg::DATL_OFF, 32'h0000_1234);
        wr(pce_pkg::DATH_OFF, 32'h0000_5678);
      end
      rdr(pce_pkg::CTRL_OFF);
      `CHK("count full", dtab[k][4:0], rd[12:8])
      `CHK("full flag", 1'b1, rd[pce_pkg::CTRL_FULL_BIT])
      `CHK("empty flag", 1'b0, rd[pce_pkg::CTRL_EMPTY_BIT])
      rdr(pce_pkg::STAT_OFF);
      `CHK("full event", 1'b1, rd[pce_pkg::IRQ_FULL])
      wr(pce_pkg::CTRL_OFF, 32'h0);
      rdr(pce_pkg::CTRL_OFF);
      `CHK("flushed", 32'h0002_0000, rd)
    end
    $display("test fifo depth done");
    run_crc(5'h1f, 32'h04c1_1db7, 5'h1f, 32'hdead_beef, 32'hffff_ffff);
    run_crc(5'h0f, 32'h0000_1021, 5'h0f, 32'hffff_1234, 32'h0000_ffff);
    run_crc(5'h07, 32'h0000_0007, 5'h07, 32'h0000_ffa5, 32'h0000_0000);
    run_crc(5'h07, 32'h0000_0006, 5'h07, 32'h0000_ffa5, 32'h0000_0000);
    run_crc(5'h04, 32'h0000_0005, 5'h04, 32'h0000_00ff, 32'h0000_0003);
    $display("test crc done");
    wr(pce_pkg::STAT_OFF, 32'h7);
    rdr(pce_pkg::RES_OFF);
    `CHK("kept", crc_ref(32'h3, 5'h04, 32'h5, 5'h04, 32'hff), rd)
    wr(pce_pkg::CTRL_OFF, 32'h3);
    repeat (4) rdr(pce_pkg::STAT_OFF);
    `CHK("idle start done", 1'b0, rd[pce_pkg::IRQ_DONE])
    wr(pce_pkg::CTRL_OFF, 32'h1);
    wr(pce_pkg::DATL_OFF, 32'h0000_00aa);
    wr(pce_pkg::CTRL_OFF, 32'h3);
    repeat (4) rdr(pce_pkg::STAT_OFF);
    `CHK("status done", 1'b1, rd[pce_pkg::IRQ_DONE])
    `CHK("irq masked", 1'b0, irq)
    wr(pce_pkg::MASK_OFF, 32'h1);
    `CHK("irq raised", 1'b1, irq)
    wr(pce_pkg::STAT_OFF, 32'h7);
    `CHK("irq cleared", 1'b0, irq)
    rdr(pce_pkg::STAT_OFF);
    `CHK("status cleared", 32'h0, rd)
    $display("test interrupt done");
    complete_run();
  end
endmodule
`default_nettype wire
